// [logic/adc_pkg.sv]
// Constants, types and helper functions shared by the dual converter control and readout.
// Overview of operation
// - Results are two's complement, 8000 to 7FFF.
// - One step is full scale over two^16.
// - Acquire after reset, power down, conversion done.
// - Chip select rising in acquire, with power down low, starts converting.
// - Both channels start converting on that same edge.
// - Conversion timed by internal clock, not serial clock.
// - Channels take start, return done and result.
// - Sixteen-bit left-justified word split over two lanes.
// - Chip select falling edge starts a readout frame.
// - Frame clocks shift out latest completed result.
// - Each channel has two lanes of its own.
// - First two bits shown at chip select falling.
// - Later bits launched on serial clock rising edges.
// - After the word, zeros on every further edge.
// - Chip select rising edge ends the frame.
// - High time picks zero or one sample latency.
// - Conversion done returns device to acquiring input.
package adc_pkg;
    localparam int RES_BITS = 16;
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_CONV_NS = 422;
    localparam int T_CYCLE_NS = 488;
    localparam int CONV_CYCLES = (T_CONV_NS / CLK_PERIOD_NS < 1) ? 1 : T_CONV_NS / CLK_PERIOD_NS;
    localparam int CYCLE_MIN_CYCLES = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] NEGATIVE_FULL_SCALE_CODE = 16'h8000;
    localparam logic [15:0] MID_SCALE_CODE = 16'h0000;
    localparam logic [15:0] POSITIVE_FULL_SCALE_CODE = 16'h7FFF;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [3:0] STEP_RESET = 4'h0;
    localparam logic [3:0] STEP_LAST = 4'h8;

    typedef logic [15:0] word_t;
    // Analog level of one input, expressed in code steps.
    typedef logic [16:0] input_t;

    typedef enum logic [1:0] {
        ACQUIRE_STATE = 2'b01,
        CONVERT_STATE = 2'b10
    } conv_state_e;

    // Converts the sampled input difference to a saturated two's complement code.
    function automatic word_t to_code(input input_t pos, input input_t neg);
        logic signed [17:0] diff;
        diff = $signed({1'b0, pos}) - $signed({1'b0, neg});
        if (diff > $signed(18'sh07FFF)) begin
            to_code = POSITIVE_FULL_SCALE_CODE;
        end else if (diff < $signed(18'sh38000)) begin
            to_code = NEGATIVE_FULL_SCALE_CODE;
        end else begin
            to_code = diff[15:0];
        end
    endfunction

    // Picks the bit shown on one lane for a given step of the frame.
    function automatic logic lane_bit(input word_t w, input logic [3:0] step, input logic upper);
        logic [4:0] idx;
        idx = 5'h0F - {step[3:0], 1'b0} - {4'h0, ~upper};
        if (step >= STEP_LAST) begin
            lane_bit = 1'b0;
        end else begin
            lane_bit = w[idx[3:0]];
        end
    endfunction
endpackage

// [logic/conv_core.sv]
// One converter channel timed by the internal system clock.
module conv_core (
    input wire logic clk_sys,
    input wire logic rst,
    conv_link_if.conv link,
    input wire adc_pkg::input_t positive_analog_input,
    input wire adc_pkg::input_t negative_analog_input
);
    import adc_pkg::*;

    logic [3:0] count;
    word_t held;

    // The input is frozen at the start, so later input changes do not affect this conversion.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            held <= RESULT_RESET;
        end else if (link.start) begin
            held <= to_code(positive_analog_input, negative_analog_input);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= COUNT_RESET;
        end else if (link.start) begin
            count <= 4'(CONV_CYCLES);
        end else if (count != COUNT_RESET) begin
            count <= count - 4'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link.done <= 1'b0;
            link.result <= RESULT_RESET;
        end else begin
            link.done <= (count == 4'h1) && !link.start;
            if (count == 4'h1 && !link.start) begin
                link.result <= held;
            end
        end
    end
endmodule

// [logic/conv_link_if.sv]
// Start, done and result signals between the control logic and one converter channel.
interface conv_link_if;
    import adc_pkg::*;
    logic start;
    logic done;
    word_t result;

    modport conv (input start, output done, output result);
    modport ctrl (output start, input done, input result);
endinterface

// [logic/dual_sar_adc_conv_readout.sv]
// Conversion control and dual-lane serial readout for two simultaneously sampled channels.
module dual_sar_adc_conv_readout (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic power_down,
    input wire adc_pkg::input_t positive_analog_input_a,
    input wire adc_pkg::input_t negative_analog_input_a,
    input wire adc_pkg::input_t positive_analog_input_b,
    input wire adc_pkg::input_t negative_analog_input_b,
    output logic chan_a_upper_lane,
    output logic chan_a_lower_lane,
    output logic chan_b_upper_lane,
    output logic chan_b_lower_lane,
    output logic lane_oe,
    output logic converting,
    output logic conversion_done_internal,
    output logic cycle_violation
);
    import adc_pkg::*;

    conv_link_if link_a ();
    conv_link_if link_b ();

    conv_state_e state;
    conv_state_e next_state;
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic pd_meta;
    logic pd_sync;
    logic cs_rise;
    logic start;
    logic [3:0] since_start;
    word_t frame_a;
    word_t frame_b;

    // Chip select and power down are pins, so both pass two flip-flops first.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            pd_meta <= 1'b0;
            pd_sync <= 1'b0;
        end else begin
            cs_meta <= cs_n;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            pd_meta <= power_down;
            pd_sync <= pd_meta;
        end
    end

    always_comb begin
        cs_rise = cs_sync && !cs_prev;
        start = cs_rise && (state == ACQUIRE_STATE) && !pd_sync;
    end

    always_comb begin
        next_state = state;
        case (state)
            ACQUIRE_STATE: begin
                if (start) begin
                    next_state = CONVERT_STATE;
                end
            end
            CONVERT_STATE: begin
                if (pd_sync || link_a.done) begin
                    next_state = ACQUIRE_STATE;
                end
            end
            default: begin
                next_state = ACQUIRE_STATE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ACQUIRE_STATE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            converting <= 1'b0;
            conversion_done_internal <= 1'b0;
        end else begin
            converting <= (next_state == CONVERT_STATE);
            conversion_done_internal <= link_a.done;
        end
    end

    // Both channels receive the same start pulse in the same cycle.
    always_comb begin
        link_a.start = start;
        link_b.start = start;
    end

    conv_core conv_a (
        .clk_sys(clk_sys),
        .rst(rst),
        .link(link_a),
        .positive_analog_input(positive_analog_input_a),
        .negative_analog_input(negative_analog_input_a)
    );

    conv_core conv_b (
        .clk_sys(clk_sys),
        .rst(rst),
        .link(link_b),
        .positive_analog_input(positive_analog_input_b),
        .negative_analog_input(negative_analog_input_b)
    );

    // Flags a start edge that comes before the minimum cycle time has passed.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            since_start <= 4'(CYCLE_MIN_CYCLES);
        end else if (start) begin
            since_start <= COUNT_RESET;
        end else if (since_start < 4'(CYCLE_MIN_CYCLES)) begin
            since_start <= since_start + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cycle_violation <= 1'b0;
        end else if (cs_rise && (since_start < 4'(CYCLE_MIN_CYCLES) || state != ACQUIRE_STATE)) begin
            cycle_violation <= 1'b1;
        end
    end

    // The frame words track the latest result while chip select is high and freeze
    // during the frame, so the serial lanes read a stable word.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frame_a <= RESULT_RESET;
            frame_b <= RESULT_RESET;
        end else if (cs_sync) begin
            frame_a <= link_a.result;
            frame_b <= link_b.result;
        end
    end

    serial_lanes lanes (
        .sclk(sclk),
        .rst(rst),
        .cs_n(cs_n),
        .frame_a(frame_a),
        .frame_b(frame_b),
        .chan_a_upper_lane(chan_a_upper_lane),
        .chan_a_lower_lane(chan_a_lower_lane),
        .chan_b_upper_lane(chan_b_upper_lane),
        .chan_b_lower_lane(chan_b_lower_lane),
        .lane_oe(lane_oe)
    );
endmodule

// [logic/serial_lanes.sv]
// Four output lanes shifted by the host's serial clock during a frame.
module serial_lanes (
    input wire logic sclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire adc_pkg::word_t frame_a,
    input wire adc_pkg::word_t frame_b,
    output logic chan_a_upper_lane,
    output logic chan_a_lower_lane,
    output logic chan_b_upper_lane,
    output logic chan_b_lower_lane,
    output logic lane_oe
);
    import adc_pkg::*;

    logic [3:0] step;

    // Chip select high clears the step at once, since the serial clock stops between frames.
    always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
        if (rst || cs_n) begin
            step <= STEP_RESET;
        end else if (step < STEP_LAST) begin
            step <= step + 4'h1;
        end
    end

    // The lanes follow chip select without waiting for a clock edge.
    always_comb begin
        chan_a_upper_lane = lane_bit(frame_a, step, 1'b1);
        chan_a_lower_lane = lane_bit(frame_a, step, 1'b0);
        chan_b_upper_lane = lane_bit(frame_b, step, 1'b1);
        chan_b_lower_lane = lane_bit(frame_b, step, 1'b0);
        lane_oe = !cs_n && !rst;
    end
endmodule

// [testbench/adc_assertions.sv]
// Concurrent checks on the ports of the dual converter readout.
module adc_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic power_down,
    input wire logic chan_a_upper_lane,
    input wire logic chan_a_lower_lane,
    input wire logic chan_b_upper_lane,
    input wire logic chan_b_lower_lane,
    input wire logic lane_oe,
    input wire logic converting,
    input wire logic conversion_done_internal,
    input wire logic cycle_violation
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] edge_cnt;
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            edge_cnt <= 4'h0;
        end else if (edge_cnt != 4'hF) begin
            edge_cnt <= edge_cnt + 4'h1;
        end
    end
    a_conv_span: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(converting) |-> ##9 ($fell(converting) && conversion_done_internal)) else $error("bad span");
    a_done_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        conversion_done_internal |=> !conversion_done_internal) else $error("long done");
    a_done_idle: assert property (@(posedge clk_sys) disable iff (rst)
        conversion_done_internal |-> !converting && $past(converting)) else $error("done w/o conv");
    a_start_cause: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(converting) |-> $past(cs_n)) else $error("start w/o cs");
    a_pd_hold: assert property (@(posedge clk_sys) disable iff (rst)
        power_down && $past(power_down, 4) |-> !$rose(converting)) else $error("start in pd");
    a_lane_enable: assert property (@(posedge clk_sys) disable iff (rst)
        lane_oe == !cs_n) else $error("bad oe");
    a_viol_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        cycle_violation |=> cycle_violation) else $error("viol lost");
    a_zero_tail: assert property (@(posedge sclk) disable iff (rst || cs_n)
        edge_cnt >= 4'h8 |-> !(chan_a_upper_lane | chan_a_lower_lane | chan_b_upper_lane | chan_b_lower_lane))
        else $error("tail");
    c_done: cover property (@(posedge clk_sys) conversion_done_internal);
    c_viol: cover property (@(posedge clk_sys) $rose(cycle_violation));
    c_tail: cover property (@(posedge sclk) edge_cnt == 4'h8);
endmodule

bind dual_sar_adc_conv_readout adc_assertions i_chk (.clk_sys, .rst, .sclk, .cs_n, .power_down,
    .chan_a_upper_lane, .chan_a_lower_lane, .chan_b_upper_lane, .chan_b_lower_lane, .lane_oe,
    .converting, .conversion_done_internal, .cycle_violation);

// [testbench/adc_host_model.sv]
// Host model that frames reads and clocks the four lanes.
module adc_host_model
    import adc_pkg::*;
(
    output logic cs_n,
    output logic sclk,
    input wire logic up_a,
    input wire logic lo_a,
    input wire logic up_b,
    input wire logic lo_b
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
    end
    // Runs a frame of n edges; the serial clock stands still outside it.
    task automatic frame(input int n, output word_t a, output word_t b, output logic tail);
        cs_n <= 1'b0;
        tail = 1'b0;
        for (int k = 0; k < n; k++) begin
            #16;
            if (k < 8) begin
                {a[15-2*k], a[14-2*k], b[15-2*k], b[14-2*k]} = {up_a, lo_a, up_b, lo_b};
            end else begin
                tail = up_a | lo_a | up_b | lo_b;
            end
            #16 sclk <= 1'b1;
            #32 sclk <= 1'b0;
        end
        #16 cs_n <= 1'b1;
    endtask
endmodule

// [testbench/dual_sar_adc_conv_readout_bench.sv]
// Bench for the dual converter control and readout.
module dual_sar_adc_conv_readout_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic power_down = 1'b0;
    input_t pa = '0, na = '0, pb = '0, nb = '0;
    logic cs_n, sclk, ua, la, ub, lb, lane_oe, converting, done, viol, tail;
    word_t ga, gb;
    int error_cnt = 0;
    int tests_run = 0;
    always #25 clk_sys = ~clk_sys;
    dual_sar_adc_conv_readout i_dut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .power_down(power_down), .positive_analog_input_a(pa), .negative_analog_input_a(na),
        .positive_analog_input_b(pb), .negative_analog_input_b(nb), .chan_a_upper_lane(ua),
        .chan_a_lower_lane(la), .chan_b_upper_lane(ub), .chan_b_lower_lane(lb), .lane_oe(lane_oe),
        .converting(converting), .conversion_done_internal(done), .cycle_violation(viol));
    adc_host_model i_host (.cs_n(cs_n), .sclk(sclk), .up_a(ua), .lo_a(la), .up_b(ub), .lo_b(lb));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic set_in(input input_t a0, input input_t a1, input input_t b0, input input_t b1);
        @(posedge clk_sys);
        {pa, na, pb, nb} <= {a0, a1, b0, b1};
    endtask
    task automatic wait_done();
        int n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        chk("done", 16'h1, {15'h0, done});
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic t_codes();
        input_t t[3][4] = '{'{17'h07FFF, 17'h0, 17'h0, 17'h08000}, '{17'h05000, 17'h05000, 17'h0, 17'h1},
            '{17'h1ABCD, 17'h0, 17'h0, 17'h01A5C}};
        word_t ea[3] = '{16'h7FFF, 16'h0000, 16'h7FFF};
        word_t eb[3] = '{16'h8000, 16'hFFFF, 16'hE5A4};
        for (int i = 0; i < 3; i++) begin
            set_in(t[i][0], t[i][1], t[i][2], t[i][3]);
            i_host.frame(9, ga, gb, tail);
            wait_done();
            i_host.frame(9, ga, gb, tail);
            chk("word a", ea[i], ga);
            chk("word b", eb[i], gb);
            chk("tail", 16'h0, {15'h0, tail});
            wait_done();
            chk("lane_oe", 16'h0, {15'h0, lane_oe});
        end
    endtask
    task automatic t_late();
        set_in(17'h00123, 17'h0, 17'h0, 17'h00456);
        i_host.frame(8, ga, gb, tail);
        wait_done();
        set_in(17'h0, 17'h0, 17'h0, 17'h0);
        i_host.frame(8, ga, gb, tail);
        repeat (4) @(posedge clk_sys);
        i_host.frame(8, ga, gb, tail);
        chk("late a", 16'h0123, ga);
        chk("late b", 16'hFBAA, gb);
        wait_done();
    endtask
    task automatic t_pd();
        @(posedge clk_sys);
        power_down <= 1'b1;
        repeat (5) @(posedge clk_sys);
        i_host.frame(1, ga, gb, tail);
        repeat (15) begin
            @(negedge clk_sys);
            chk("pd conv", 16'h0, {15'h0, converting});
        end
        @(posedge clk_sys);
        power_down <= 1'b0;
        repeat (5) @(posedge clk_sys);
    endtask
    task automatic t_viol();
        chk("viol idle", 16'h0, {15'h0, viol});
        i_host.frame(1, ga, gb, tail);
        repeat (4) @(posedge clk_sys);
        i_host.frame(1, ga, gb, tail);
        repeat (8) @(negedge clk_sys);
        chk("viol", 16'h1, {15'h0, viol});
    endtask
    task automatic test_done();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (20) @(posedge clk_sys);
        t_codes();
        t_late();
        t_pd();
        t_viol();
        test_done();
    end
endmodule
